/* adc_conversion_sequencer.sv */
// Purpose: control sequencer of a 10-bit successive-approximation converter
// Assumes: all inputs synchronous to clk_sys except trigger lines, which are resynchronised
// Notes: registers reached over APB with one wait-free access phase
//
// Overview of operation
// RULE1: writing one to start begins a conversion; bit stays set, hardware clears it.
// RULE2: a new channel request is applied only after the running conversion ends; while free running, it is held until free running stops.
// RULE3: auto-triggering works only with auto enable set; source chosen by select field.
// RULE4: rising edge on selected trigger resets prescaler and starts a conversion.
// RULE5: trigger level held high starts nothing; edges during a conversion are ignored.
// RULE6: source flags act as triggers regardless of any interrupt enables.
// RULE7: software clears the source flag before the next event to retrigger.
// RULE8: with own done flag as source, each finished conversion starts the next.
// RULE9: software starts the first free-running conversion through the start bit.
// RULE10: start bit launches single conversions under auto mode; reads one while converting.
// RULE11: software keeps converter clock 50 kHz to 4 MHz, 2 MHz differential.
// RULE12: converter clock is system clock divided by prescaler; held reset while disabled.
// RULE13: enable powers the regulator first; startup waits for supply ok.
// RULE14: startup lasts four times startup field plus one converter clocks.
// RULE15: differential adds gain init of twice track field plus two clocks.
// RULE16: software waits 20 us or discards first result when startup is short.
// RULE17: fixed start-to-sample delay set by prescaler code or two differential clocks.
// RULE18: triggered starts add three system cycles for trigger synchronisation.
// RULE19: every conversion lasts exactly 11 converter clocks.
// RULE20: on completion store result, set done flag, clear start in single mode.
// RULE21: tracking phase follows each conversion; no new start before it ends.
// RULE22: free running keeps start set and restarts right after tracking.
// RULE23: selected trigger is synchronised and edge-detected against its previous sample.
//
// Decided for this implementation: the register addresses and register access over APB.
`default_nettype none
module adc_conversion_sequencer #(
	parameter int TRIG_W = 8
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// trigger source flags
	input wire logic [TRIG_W-1:0] triggerFlags,
	// analog core
	input wire logic analogSupplyOk,
	input wire logic [adc_seq_pkg::RESULT_W-1:0] coreResult,
	output adc_seq_pkg::analog_ctl_s analogCtl
);
	import adc_seq_pkg::*;

	initial begin
		if (TRIG_W < 2 || TRIG_W > 8) begin
			$error("TRIG_W must be 2 to 8");
		end
	end

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [6:0] divRatio(input logic [2:0] ps);
		logic [6:0] r;
		r = 7'd1;
		if (ps == 3'd0) begin
			r = 7'd1;
		end else begin
			r = 7'(7'd1 << (ps - 3'd1));
		end
		return r;
	endfunction

	function automatic logic [6:0] seDelay(input logic [2:0] ps);
		logic [6:0] d;
		d = 7'd0;
		if (ps < 3'd2) begin
			d = DLY_FAST;
		end else if (ps == 3'd2) begin
			d = DLY_MID;
		end
		return d;
	endfunction

	// ************************************************************
	// declarations
	// ************************************************************
	seq_cfg_s cfg_q, cfg_d;
	seq_state_e state_q, state_d;
	logic [7:0] cnt_q, cnt_d;
	logic [6:0] cyc_q, cyc_d;
	logic [6:0] pres_q, pres_d;
	logic tick;
	logic trigS1_q, trigS2_q, trigPrev_q;
	logic trigS1_d, trigS2_d, trigPrev_d;
	logic pend_q, pend_d, pendAuto_q, pendAuto_d, curAuto_q, curAuto_d;
	logic startBit_q, startBit_d, done_q, done_d;
	logic [RESULT_W-1:0] result_q, result_d;
	logic [4:0] chanReq_q, chanReq_d, chanApp_q, chanApp_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	analog_ctl_s ana_q, ana_d;
	logic wrEn, busy, freeRun, trigEdge, acceptEdge, swStart, launch, convDone, sample;
	logic [7:0] startupLen, gainLen, trackLen;
	logic [6:0] launchDly;
	logic trackDone;

	assign wrEn = psel & penable & pready_q & pwrite;
	assign busy = (state_q == ST_DELAY) || (state_q == ST_CONV);
	assign freeRun = cfg_q.autoTrig && (cfg_q.triggerSourceSelect == 3'd0);
	assign startupLen = 8'({cfg_q.startupTimeField, 2'b00}) + 8'd4; // RULE14
	assign gainLen = 8'({cfg_q.trackHoldTimeField, 1'b0}) + 8'd4; // RULE15
	assign trackLen = cfg_q.differential ?
		8'({cfg_q.trackHoldTimeField, 1'b0}) + 8'd3 : // RULE21
		8'(cfg_q.trackHoldTimeField) + 8'd1; // RULE21
	assign swStart = wrEn && (paddr == OFS_CTRL_A) && pwdata[A_START] && pwdata[A_ENABLE]
		&& cfg_q.enable && !startBit_q; // RULE1 RULE10
	assign trigEdge = trigS2_q & ~trigPrev_q; // RULE23
	assign acceptEdge = cfg_q.enable && cfg_q.autoTrig && !freeRun && trigEdge && !busy
		&& !startBit_q; // RULE3 RULE5

	// ************************************************************
	// configuration registers
	// ************************************************************
	always_comb begin
		cfg_d = cfg_q;
		chanReq_d = chanReq_q;
		if (wrEn && paddr == OFS_CTRL_A) begin
			cfg_d.enable = pwdata[A_ENABLE];
			cfg_d.autoTrig = pwdata[A_AUTO]; // RULE3
			cfg_d.prescalerSelect = pwdata[A_PRES_LSB +: 3];
		end else if (wrEn && paddr == OFS_CTRL_B) begin
			cfg_d.differential = pwdata[B_DIFF];
			cfg_d.triggerSourceSelect = pwdata[B_TSRC_LSB +: 3]; // RULE3
		end else if (wrEn && paddr == OFS_CTRL_C) begin
			cfg_d.startupTimeField = pwdata[C_SUT_LSB +: 5];
			cfg_d.trackHoldTimeField = pwdata[C_THT_LSB +: 2];
		end else if (wrEn && paddr == OFS_CHANNEL) begin
			chanReq_d = pwdata[CH_REQ_LSB +: 5];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= '{1'b0, 1'b0, PRES_RST, 1'b0, TSRC_RST, SUT_RST, THT_RST};
			chanReq_q <= CHAN_RST;
		end else begin
			cfg_q <= cfg_d;
			chanReq_q <= chanReq_d;
		end
	end

	// ************************************************************
	// prescaler
	// ************************************************************
	always_comb begin
		tick = (pres_q == divRatio(cfg_q.prescalerSelect) * 7'd2 - 7'd1);
		pres_d = tick ? 7'd0 : pres_q + 7'd1;
		if (sample) begin
			pres_d = 7'd0; // RULE19
		end
		if (!cfg_q.enable || acceptEdge) begin
			pres_d = 7'd0; // RULE12 RULE4
			tick = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pres_q <= 7'd0;
		end else begin
			pres_q <= pres_d;
		end
	end

	// ************************************************************
	// trigger synchroniser
	// ************************************************************
	always_comb begin
		trigS1_d = triggerFlags[cfg_q.triggerSourceSelect]; // RULE3 RULE6
		trigS2_d = trigS1_q; // RULE23
		trigPrev_d = trigS2_q; // RULE23
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			trigS1_q <= 1'b0;
			trigS2_q <= 1'b0;
			trigPrev_q <= 1'b0;
		end else begin
			trigS1_q <= trigS1_d;
			trigS2_q <= trigS2_d;
			trigPrev_q <= trigPrev_d;
		end
	end

	// ************************************************************
	// sequencer
	// ************************************************************
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		cyc_d = cyc_q;
		curAuto_d = curAuto_q;
		convDone = 1'b0;
		sample = 1'b0;
		trackDone = ((cnt_q == trackLen) || (tick && cnt_q == trackLen - 8'd1))
			&& (cfg_q.differential || cyc_q == 7'd0); // RULE21 RULE22
		launch = pend_q && ((state_q == ST_IDLE) || (state_q == ST_TRACK && trackDone)); // RULE21
		if (cfg_q.differential) begin
			launchDly = pendAuto_q ? TRIG_SYNC_CYC : 7'd0; // RULE17 RULE18
		end else begin
			launchDly = seDelay(cfg_q.prescalerSelect) + (pendAuto_q ? TRIG_SYNC_CYC : 7'd0); // RULE17 RULE18
		end
		case (state_q)
			ST_OFF: begin
				if (cfg_q.enable) begin
					state_d = ST_REGUP; // RULE13
				end
			end
			ST_REGUP: begin
				if (analogSupplyOk) begin
					state_d = ST_STARTUP; // RULE13
					cnt_d = 8'd0;
				end
			end
			ST_STARTUP: begin
				if (tick) begin
					cnt_d = cnt_q + 8'd1;
					if (cnt_q == startupLen - 8'd1) begin
						state_d = cfg_q.differential ? ST_GAIN : ST_IDLE; // RULE14 RULE15
						cnt_d = 8'd0;
					end
				end
			end
			ST_GAIN: begin
				if (tick) begin
					cnt_d = cnt_q + 8'd1;
					if (cnt_q == gainLen - 8'd1) begin
						state_d = ST_IDLE; // RULE15
						cnt_d = 8'd0;
					end
				end
			end
			ST_IDLE: begin
			end
			ST_DELAY: begin
				if (cyc_q != 7'd0) begin
					cyc_d = cyc_q - 7'd1;
					if (!cfg_q.differential && cyc_q == 7'd1) begin
						state_d = ST_CONV; // RULE17
						sample = 1'b1;
					end
				end else if (tick) begin
					cnt_d = cnt_q + 8'd1;
					if (cnt_q == DIFF_DLY_TICKS - 8'd1) begin
						state_d = ST_CONV; // RULE17
						cnt_d = 8'd0;
						sample = 1'b1;
					end
				end
			end
			ST_CONV: begin
				if (tick) begin
					cnt_d = cnt_q + 8'd1;
					if (cnt_q == CONV_TICKS - 8'd1) begin
						convDone = 1'b1; // RULE19
						state_d = ST_TRACK; // RULE21
						cnt_d = 8'd0;
						cyc_d = 7'(TRACK_MIN_CYC);
					end
				end
			end
			ST_TRACK: begin
				if (cyc_q != 7'd0) begin
					cyc_d = cyc_q - 7'd1;
				end
				if (tick && cnt_q != trackLen) begin
					cnt_d = cnt_q + 8'd1;
				end
				if (trackDone) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_OFF;
			end
		endcase
		if (launch) begin
			curAuto_d = pendAuto_q;
			cnt_d = 8'd0;
			cyc_d = launchDly;
			if (launchDly == 7'd0 && !cfg_q.differential) begin
				state_d = ST_CONV; // RULE17
				sample = 1'b1;
			end else begin
				state_d = ST_DELAY;
			end
		end
		if (!cfg_q.enable) begin
			state_d = ST_OFF; // RULE12
			cnt_d = 8'd0;
			cyc_d = 7'd0;
			curAuto_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_OFF;
			cnt_q <= 8'd0;
			cyc_q <= 7'd0;
			curAuto_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			cyc_q <= cyc_d;
			curAuto_q <= curAuto_d;
		end
	end

	// ************************************************************
	// start requests, flags and result
	// ************************************************************
	always_comb begin
		pend_d = pend_q;
		pendAuto_d = pendAuto_q;
		startBit_d = startBit_q;
		done_d = done_q;
		result_d = result_q;
		chanApp_d = chanApp_q;
		if (launch) begin
			pend_d = 1'b0;
			pendAuto_d = 1'b0;
			startBit_d = 1'b1; // RULE10
		end
		if (swStart) begin
			pend_d = 1'b1; // RULE1 RULE9
			pendAuto_d = 1'b0;
			startBit_d = 1'b1; // RULE1
		end else if (acceptEdge) begin
			pend_d = 1'b1; // RULE4
			pendAuto_d = 1'b1; // RULE18
		end
		if (convDone) begin
			result_d = coreResult; // RULE20
			if (freeRun) begin
				pend_d = 1'b1; // RULE8 RULE22
				pendAuto_d = 1'b0;
			end else if (!swStart) begin
				startBit_d = 1'b0; // RULE1 RULE20
			end
		end
		if (wrEn && paddr == OFS_CTRL_A && pwdata[A_DONE]) begin
			done_d = 1'b0;
		end
		if (convDone) begin
			done_d = 1'b1; // RULE20
		end
		if (!busy && !pend_q) begin
			chanApp_d = chanReq_q; // RULE2
		end
		if (!cfg_q.enable) begin
			pend_d = 1'b0;
			pendAuto_d = 1'b0;
			startBit_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
			pendAuto_q <= 1'b0;
			startBit_q <= 1'b0;
			done_q <= 1'b0;
			result_q <= '0;
			chanApp_q <= CHAN_RST;
		end else begin
			pend_q <= pend_d;
			pendAuto_q <= pendAuto_d;
			startBit_q <= startBit_d;
			done_q <= done_d;
			result_q <= result_d;
			chanApp_q <= chanApp_d;
		end
	end

	// ************************************************************
	// analog core controls
	// ************************************************************
	always_comb begin
		ana_d.regulatorOn = cfg_q.enable; // RULE13
		ana_d.corePowerOn = cfg_q.enable && state_q != ST_OFF && state_q != ST_REGUP; // RULE13
		ana_d.gainAmpOn = ana_d.corePowerOn && cfg_q.differential;
		ana_d.adcClock = cfg_q.enable && (pres_q >= divRatio(cfg_q.prescalerSelect)); // RULE12
		ana_d.sampleHold = sample;
		ana_d.converting = (state_d == ST_CONV);
		ana_d.channel = chanApp_q;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ana_q <= '0;
		end else begin
			ana_q <= ana_d;
		end
	end

	// ************************************************************
	// apb slave
	// ************************************************************
	always_comb begin
		prdata_d = 32'h0000_0000;
		pslverr_d = 1'b0;
		pready_d = psel & ~penable;
		if (psel && !penable) begin
			if (paddr == OFS_CTRL_A) begin
				prdata_d[A_ENABLE] = cfg_q.enable;
				prdata_d[A_START] = startBit_q; // RULE10
				prdata_d[A_AUTO] = cfg_q.autoTrig;
				prdata_d[A_DONE] = done_q;
				prdata_d[A_PRES_LSB +: 3] = cfg_q.prescalerSelect;
			end else if (paddr == OFS_CTRL_B) begin
				prdata_d[B_SUPPLY_OK] = analogSupplyOk && cfg_q.enable; // RULE13
				prdata_d[B_DIFF] = cfg_q.differential;
				prdata_d[B_TSRC_LSB +: 3] = cfg_q.triggerSourceSelect;
			end else if (paddr == OFS_CTRL_C) begin
				prdata_d[C_SUT_LSB +: 5] = cfg_q.startupTimeField;
				prdata_d[C_THT_LSB +: 2] = cfg_q.trackHoldTimeField;
			end else if (paddr == OFS_RESULT) begin
				prdata_d[RESULT_W-1:0] = result_q;
			end else if (paddr == OFS_CHANNEL) begin
				prdata_d[CH_REQ_LSB +: 5] = chanReq_q;
				prdata_d[CH_APP_LSB +: 5] = chanApp_q;
			end else begin
				pslverr_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign analogCtl = ana_q;
endmodule // adc_conversion_sequencer
`default_nettype wire

/* adc_conversion_sequencer_tb.sv */
// Purpose: self-checking bench of the conversion sequencer
// Assumes: APB master tasks, analog core model as partner
// Notes: timings measured on analogCtl.converting
`default_nettype none
module adc_conversion_sequencer_tb;
	import adc_seq_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, analogSupplyOk, wasConv, re;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rq;
	logic [7:0] triggerFlags;
	logic [RESULT_W-1:0] coreResult, nextResult;
	analog_ctl_s analogCtl;
	int fail_count, checks, riseCount, convLen, period, base, n;
	int dly[3];
	int codes[3] = '{0, 2, 3};
	int ratio[3] = '{2, 4, 8};
	time riseT, takeT, tStart;
	adc_conversion_sequencer #(.TRIG_W(8)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .triggerFlags(triggerFlags),
		.analogSupplyOk(analogSupplyOk), .coreResult(coreResult), .analogCtl(analogCtl));
	adc_core_model core_u (.clk_sys(clk_sys), .rst_n(rst_n), .analogCtl(analogCtl),
		.nextResult(nextResult), .analogSupplyOk(analogSupplyOk), .coreResult(coreResult));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (analogCtl.converting && !wasConv) begin
			riseCount++;
			period = int'(($time - riseT) / 10);
			riseT = $time;
		end
		if (!analogCtl.converting && wasConv) convLen = int'(($time - riseT) / 10);
		wasConv = analogCtl.converting;
	end
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1 && k < 50) begin
			@(posedge clk_sys);
			k++;
		end
		if (k == 50) fail_count++;
		rq = prdata;
		re = pslverr;
		takeT = $time;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic waitIdle();
		int k;
		k = 0;
		xfer(1'b0, OFS_CTRL_A, 32'h0000_0000);
		while (rq[6] === 1'b1 && k < 400) begin
			xfer(1'b0, OFS_CTRL_A, 32'h0000_0000);
			k++;
		end
	endtask
	task automatic close_out();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#1000000;
		fail_count++;
		close_out();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, triggerFlags, rst_n, wasConv} = '0;
		nextResult = 10'h2a5;
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			xfer(1'b0, 12'(4 * i), 32'h0000_0000);
			chk(rq, 32'h0000_0000);
		end
		xfer(1'b0, 12'h014, 32'h0000_0000);
		chk({rq[30:0], re}, 32'h0000_0001);
		xfer(1'b1, OFS_CTRL_C, 32'h0000_0000);
		xfer(1'b1, OFS_CTRL_A, 32'h0000_0080);
		n = 0;
		do begin
			xfer(1'b0, OFS_CTRL_B, 32'h0000_0000);
			n++;
		end while (rq[7] !== 1'b1 && n < 100);
		chk(rq & 32'h0000_0080, 32'h0000_0080);
		repeat (40) @(posedge clk_sys);
		for (int i = 0; i < 3; i++) begin
			nextResult <= 10'(10'h100 + i);
			xfer(1'b1, OFS_CTRL_A, 32'h0000_00c0 | 32'(codes[i]));
			tStart = takeT;
			xfer(1'b1, OFS_CHANNEL, 32'(i + 1));
			xfer(1'b0, OFS_CHANNEL, 32'h0000_0000);
			chk(32'(rq[12:8]), 32'(i));
			xfer(1'b0, OFS_CTRL_A, 32'h0000_0000);
			chk(rq & 32'h0000_0040, 32'h0000_0040);
			waitIdle();
			chk(rq & 32'h0000_0050, 32'h0000_0010);
			chk(32'(convLen), 32'(11 * ratio[i]));
			dly[i] = int'((riseT - tStart) / 10);
			xfer(1'b0, OFS_RESULT, 32'h0000_0000);
			chk(rq, 32'(nextResult));
			xfer(1'b0, OFS_CHANNEL, 32'h0000_0000);
			chk(32'(rq[12:8]), 32'(i + 1));
			repeat (100) @(posedge clk_sys);
		end
		chk(32'(dly[0] - dly[2]), 32'h0000_0002);
		chk(32'(dly[1] - dly[2]), 32'h0000_0004);
		xfer(1'b1, OFS_CTRL_A, 32'h0000_0093);
		xfer(1'b0, OFS_CTRL_A, 32'h0000_0000);
		chk(rq & 32'h0000_0010, 32'h0000_0000);
		xfer(1'b1, OFS_CTRL_B, 32'h0000_0002);
		base = riseCount;
		triggerFlags[2] <= 1'b1;
		repeat (200) @(posedge clk_sys);
		chk(32'(riseCount - base), 32'h0000_0000);
		triggerFlags[2] <= 1'b0;
		xfer(1'b1, OFS_CTRL_A, 32'h0000_00a3);
		base = riseCount;
		triggerFlags[2] <= 1'b1;
		repeat (30) @(posedge clk_sys);
		xfer(1'b0, OFS_CTRL_A, 32'h0000_0000);
		chk(rq & 32'h0000_0040, 32'h0000_0040);
		triggerFlags[2] <= 1'b0;
		repeat (2) @(posedge clk_sys);
		triggerFlags[2] <= 1'b1;
		repeat (300) @(posedge clk_sys);
		chk(32'(riseCount - base), 32'h0000_0001);
		triggerFlags[2] <= 1'b0;
		repeat (3) @(posedge clk_sys);
		triggerFlags[2] <= 1'b1;
		repeat (300) @(posedge clk_sys);
		chk(32'(riseCount - base), 32'h0000_0002);
		xfer(1'b1, OFS_CTRL_B, 32'h0000_0000);
		base = riseCount;
		xfer(1'b1, OFS_CTRL_A, 32'h0000_00e6);
		n = 0;
		while (riseCount - base < 3 && n < 4000) begin
			@(posedge clk_sys);
			n++;
		end
		chk(32'(period), 32'(12 * 64));
		xfer(1'b0, OFS_CTRL_A, 32'h0000_0000);
		chk(rq & 32'h0000_0040, 32'h0000_0040);
		xfer(1'b1, OFS_CTRL_A, 32'h0000_0086);
		waitIdle();
		chk(rq & 32'h0000_0040, 32'h0000_0000);
		close_out();
	end
endmodule // adc_conversion_sequencer_tb
`default_nettype wire

/* adc_core_model.sv */
// Purpose: behavioural model of the analog converter core
// Assumes: driven by the sequencer's analogCtl struct
// Notes: result is only valid around a conversion, inverted otherwise
`default_nettype none
module adc_core_model
	import adc_seq_pkg::*;
#(
	parameter int SUPPLY_DLY = 20
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// control from the sequencer, next result value from the bench
	input wire adc_seq_pkg::analog_ctl_s analogCtl,
	input wire logic [adc_seq_pkg::RESULT_W-1:0] nextResult,
	// status and data to the sequencer
	output logic analogSupplyOk,
	output logic [adc_seq_pkg::RESULT_W-1:0] coreResult
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] upCnt_q;
	logic hold_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			upCnt_q <= 8'h00;
			hold_q <= 1'b0;
		end else begin
			if (!analogCtl.regulatorOn) begin
				upCnt_q <= 8'h00;
			end else if (upCnt_q < SUPPLY_DLY) begin
				upCnt_q <= upCnt_q + 8'h01;
			end
			hold_q <= analogCtl.converting;
		end
	end
	assign analogSupplyOk = analogCtl.regulatorOn && (upCnt_q >= SUPPLY_DLY);
	assign coreResult = (analogCtl.converting || hold_q) ? nextResult : ~nextResult;
endmodule // adc_core_model
`default_nettype wire

/* adc_seq_chk_sva.sv */
// Purpose: port-level assertions of the conversion sequencer
// Assumes: 100 MHz clk_sys, asynchronous active-low reset
// Notes: attached by bind below
`default_nettype none
module adc_seq_chk
	import adc_seq_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// analog core
	input wire adc_seq_pkg::analog_ctl_s analogCtl
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] convCnt_q;
	logic [11:0] convCnt_d;
	always_comb begin
		convCnt_d = analogCtl.converting ? convCnt_q + 12'h001 : 12'h000;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			convCnt_q <= 12'h000;
		end else begin
			convCnt_q <= convCnt_d;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	AST_PREADY_ACCESS: assert property (psel && !penable |=> pready)
		else $error("no answer in access phase");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error response malformed");
	AST_IDLE_RDATA: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside access");
	AST_CORE_NEEDS_REG: assert property (analogCtl.corePowerOn |-> analogCtl.regulatorOn)
		else $error("core powered without regulator");
	AST_CONV_LEN: assert property ($fell(analogCtl.converting) |->
		convCnt_q % 22 == 0 && convCnt_q >= 22 && convCnt_q <= 2816)
		else $error("conversion length wrong");
	AST_TRACK_GAP: assert property ($fell(analogCtl.converting) |-> !analogCtl.converting[*6])
		else $error("conversion restarted without tracking");
	AST_CHAN_HOLD: assert property (analogCtl.converting && $past(analogCtl.converting) |->
		$stable(analogCtl.channel))
		else $error("channel changed in conversion");
	AST_SAMPLE_PULSE: assert property (analogCtl.sampleHold |=> !analogCtl.sampleHold)
		else $error("sample pulse too long");
	AST_CLK_HELD: assert property ($rose(analogCtl.regulatorOn) |-> !analogCtl.adcClock)
		else $error("prescaler runs while disabled");
endmodule // adc_seq_chk
bind adc_conversion_sequencer adc_seq_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .analogCtl(analogCtl));
`default_nettype wire

/* adc_seq_pkg.sv */
// Purpose: shared constants, types and register map of the conversion sequencer
// Assumes: 100 MHz system clock, APB register access with 32-bit data
// Notes: register words are aligned; unused bits read as zero
`default_nettype none
package adc_seq_pkg;
	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [11:0] OFS_CTRL_A = 12'h000;
	localparam logic [11:0] OFS_CTRL_B = 12'h004;
	localparam logic [11:0] OFS_CTRL_C = 12'h008;
	localparam logic [11:0] OFS_RESULT = 12'h00c;
	localparam logic [11:0] OFS_CHANNEL = 12'h010;
	// ************************************************************
	// field positions
	// ************************************************************
	localparam int A_ENABLE = 7;
	localparam int A_START = 6;
	localparam int A_AUTO = 5;
	localparam int A_DONE = 4;
	localparam int A_PRES_LSB = 0;
	localparam int B_SUPPLY_OK = 7;
	localparam int B_DIFF = 3;
	localparam int B_TSRC_LSB = 0;
	localparam int C_SUT_LSB = 0;
	localparam int C_THT_LSB = 8;
	localparam int CH_REQ_LSB = 0;
	localparam int CH_APP_LSB = 8;
	// ************************************************************
	// reset values and timing
	// ************************************************************
	localparam logic [2:0] PRES_RST = 3'h0;
	localparam logic [2:0] TSRC_RST = 3'h0;
	localparam logic [4:0] SUT_RST = 5'h00;
	localparam logic [1:0] THT_RST = 2'h0;
	localparam logic [4:0] CHAN_RST = 5'h00;
	localparam int CLK_MHZ = 100;
	localparam int TRACK_MIN_NS = 500;
	localparam int TRACK_MIN_CYC = (TRACK_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] CONV_TICKS = 8'd11;
	localparam logic [6:0] TRIG_SYNC_CYC = 7'd3;
	localparam logic [6:0] DLY_FAST = 7'd2;
	localparam logic [6:0] DLY_MID = 7'd4;
	localparam logic [7:0] DIFF_DLY_TICKS = 8'd2;
	localparam int RESULT_W = 10;
	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_REGUP = 3'b001,
		ST_STARTUP = 3'b011,
		ST_GAIN = 3'b010,
		ST_IDLE = 3'b110,
		ST_DELAY = 3'b111,
		ST_CONV = 3'b101,
		ST_TRACK = 3'b100
	} seq_state_e;
	typedef struct packed {
		logic enable;
		logic autoTrig;
		logic [2:0] prescalerSelect;
		logic differential;
		logic [2:0] triggerSourceSelect;
		logic [4:0] startupTimeField;
		logic [1:0] trackHoldTimeField;
	} seq_cfg_s;
	typedef struct packed {
		logic regulatorOn;
		logic corePowerOn;
		logic gainAmpOn;
		logic adcClock;
		logic sampleHold;
		logic converting;
		logic [4:0] channel;
	} analog_ctl_s;
endpackage
`default_nettype wire
